/* File: rtl/bca_pkg.sv */
// Shared constants and types for the bit crush and alias effect
package bca_pkg;
    // Sample format and processing rates
    localparam int SAMPLE_W = 24;
    localparam int SAMPLE_RATE_HZ = 48000;
    localparam int MAX_BITS = 24;
    localparam int DB_PER_BIT_X10 = 60;
    localparam int RANGE_DB_PER_BIT = 6;
    localparam int DB_MANT_STEP = 68;
    localparam int LIN_FRAC_W = 12;
    localparam int DC_UNITY_LOG2 = 23;
    localparam int GAIN_UNITY_LOG2 = 12;
    localparam int MIX_COEF_W = 7;
    localparam int MIX_PCT_MUL = 41;
    localparam int MIX_PCT_SHIFT = 5;
    localparam int CENT_STEP_Q16 = 38;
    localparam int UNITY_Q16 = 65536;
    localparam int PHASE_W = 24;
    localparam int PHASE_SHIFT = 24;
    localparam longint PHASE_K = (64'd1 << 32) / SAMPLE_RATE_HZ;
    localparam int DEPTH_MIN = 1;
    localparam int DEPTH_MAX = 49;
    localparam int MEM_AW = 6;

    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_QUANT = 8'h04;
    localparam logic [7:0] REG_DC_BIAS = 8'h08;
    localparam logic [7:0] REG_MIX = 8'h0C;
    localparam logic [7:0] REG_MOD_FREQ = 8'h10;
    localparam logic [7:0] REG_MOD_DEPTH = 8'h14;
    localparam logic [7:0] REG_OUT_GAIN = 8'h18;
    localparam logic [7:0] REG_STATUS = 8'h1C;

    // Field positions
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_MUTE_BIT = 1;
    localparam int QUANT_RANGE_LSB = 0;
    localparam int QUANT_HEAD_LSB = 8;
    localparam int MIX_QUANT_LSB = 0;
    localparam int MIX_ALIAS_LSB = 8;
    localparam int MODF_COARSE_LSB = 0;
    localparam int MODF_FINE_LSB = 16;
    localparam int STATUS_BUSY_BIT = 16;

    // Reset values
    localparam logic RST_ENABLE = 1'b0;
    localparam logic RST_MUTE = 1'b0;
    localparam logic [7:0] RST_RANGE_DB = 8'h90;
    localparam logic [7:0] RST_HEAD_DB = 8'h00;
    localparam logic signed [10:0] RST_DC_DB = -11'sd790;
    localparam logic [6:0] RST_QUANT_MIX = 7'h64;
    localparam logic [6:0] RST_ALIAS_MIX = 7'h64;
    localparam logic [14:0] RST_COARSE_HZ = 15'h01B8;
    localparam logic signed [7:0] RST_FINE_CT = 8'sh00;
    localparam logic [5:0] RST_DEPTH = 6'h01;
    localparam logic signed [10:0] RST_GAIN_DB = 11'sh000;

    typedef struct packed {
        logic enable;
        logic mute;
        logic [7:0] range_db;
        logic [7:0] headroom_db;
        logic signed [10:0] dc_bias_level;
        logic [6:0] quant_mix;
        logic [6:0] alias_mix;
        logic [14:0] coarse_hz;
        logic signed [7:0] fine_ct;
        logic [5:0] modulation_depth;
        logic signed [10:0] gain_db;
    } bca_settings_t;

    typedef struct packed {
        logic valid;
        logic signed [SAMPLE_W-1:0] data;
    } bca_sample_t;
endpackage

/* File: rtl/bca_delay_mem.sv */
// Small delay line memory with registered read data
`timescale 1ns/1ns
module bca_delay_mem #(
    parameter int AW = 6,
    parameter int DW = 24
) (
    // Clock
    input wire logic i_clock,
    // Write port
    input wire logic i_wr_en,
    input wire logic [AW-1:0] i_wr_addr,
    input wire logic [DW-1:0] i_wr_data,
    // Read port
    input wire logic [AW-1:0] i_rd_addr,
    output logic [DW-1:0] o_rd_data
);
    logic [DW-1:0] mem_q [2**AW];

    // No reset on the array; stale words only colour the first frames
    always_ff @(posedge i_clock) begin
        if (i_wr_en) begin
            mem_q[i_wr_addr] <= i_wr_data;
        end
    end

    always_ff @(posedge i_clock) begin
        o_rd_data <= mem_q[i_rd_addr];
    end
endmodule

/* File: rtl/bca_effect.sv */
// Bit crush then simulated alias effect with an AHB-Lite register slave
//
// Decided for this implementation: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ns
module bca_effect #(
    parameter int SAMPLE_W = bca_pkg::SAMPLE_W
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // AHB-Lite slave
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    // Sample input
    input wire bca_pkg::bca_sample_t i_in,
    output logic o_in_ready,
    // Sample output
    output bca_pkg::bca_sample_t o_out
);
    typedef enum {
        BCA_IDLE, BCA_BIAS, BCA_QUANT, BCA_QMIX, BCA_ALIAS, BCA_AMIX,
        BCA_GAIN
    } bca_state_t;

    typedef logic signed [SAMPLE_W-1:0] bca_word_t;

    localparam logic signed [SAMPLE_W:0] SAT_MAX = (SAMPLE_W+1)'(
        (1 << (SAMPLE_W - 1)) - 1);
    localparam logic signed [SAMPLE_W:0] SAT_MIN = -SAT_MAX - 1;

    // Tenth-dB to linear: about 6 dB per octave, linear in between
    function automatic logic [31:0] db_lin(input logic signed [10:0] db,
                                           input int ulog);
        int q;
        int r;
        logic [63:0] m;
        q = (int'(db) >= 0) ? int'(db) / bca_pkg::DB_PER_BIT_X10 :
            -((bca_pkg::DB_PER_BIT_X10 - 1 - int'(db)) /
              bca_pkg::DB_PER_BIT_X10);
        r = int'(db) - bca_pkg::DB_PER_BIT_X10 * q;
        m = 64'((1 << bca_pkg::LIN_FRAC_W) + r * bca_pkg::DB_MANT_STEP);
        m = m << ulog;
        if (q >= 0) begin
            m = m << q;
        end else begin
            m = m >> (-q);
        end
        return 32'(m >> bca_pkg::LIN_FRAC_W);
    endfunction

    // Saturate a wide sum into the sample word
    function automatic bca_word_t sat(input logic signed [47:0] v);
        if (v > 48'(SAT_MAX)) begin
            return SAT_MAX[SAMPLE_W-1:0];
        end else if (v < 48'(SAT_MIN)) begin
            return SAT_MIN[SAMPLE_W-1:0];
        end
        return v[SAMPLE_W-1:0];
    endfunction

    // Bits kept for a range setting in dB
    function automatic logic [4:0] kept_bits(input logic [7:0] db);
        logic [7:0] b;
        b = 8'(db / bca_pkg::RANGE_DB_PER_BIT) + 8'h01;
        if (b > 8'(bca_pkg::MAX_BITS)) begin
            b = 8'(bca_pkg::MAX_BITS);
        end
        return b[4:0];
    endfunction

    // Percent to a Q7 mix coefficient, 100 percent maps to 128
    function automatic logic [7:0] pct_coef(input logic [6:0] pct);
        logic [15:0] p;
        p = 16'(pct) * 16'(bca_pkg::MIX_PCT_MUL);
        p = p >> bca_pkg::MIX_PCT_SHIFT;
        return p[7:0];
    endfunction

    // Crossfade dry toward wet by a Q7 or Q8 coefficient
    function automatic bca_word_t blend(input bca_word_t dry,
                                        input bca_word_t wet,
                                        input logic [8:0] coef,
                                        input int sh);
        logic signed [47:0] diff;
        diff = 48'(wet) - 48'(dry);
        diff = (diff * $signed({1'b0, coef})) >>> sh;
        return sat(48'(dry) + diff);
    endfunction

    // Bus state
    logic [7:0] ap_addr_q;
    logic ap_write_q;
    logic ap_valid_q;
    logic bus_take;
    logic [15:0] sample_count_q;
    bca_pkg::bca_settings_t reg_q;

    // Datapath state
    bca_state_t state_q;
    bca_pkg::bca_settings_t cfg_q;
    bca_word_t in_q;
    bca_word_t bias_q;
    bca_word_t quant_q;
    bca_word_t stage1_q;
    bca_word_t alias_q;
    bca_word_t stage2_q;
    logic [bca_pkg::PHASE_W-1:0] phase_q;
    logic [bca_pkg::MEM_AW-1:0] wr_ptr_q;
    logic [bca_pkg::MEM_AW-1:0] rd_addr;
    bca_word_t rd_data;
    logic mem_we;

    // Derived from the latched settings, except tri_w from the alias phase
    logic [31:0] dc_lin;
    logic [31:0] gain_lin;
    logic [4:0] cut;
    logic [4:0] boost;
    logic [7:0] tri_w;
    logic [bca_pkg::PHASE_W-1:0] phase_inc;
    logic [5:0] depth_c;

    assign bus_take = i_hsel & i_htrans[1] & i_hready;

    // Address phase capture; the slave never inserts wait states
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            ap_addr_q <= 8'h00;
            ap_write_q <= 1'b0;
            ap_valid_q <= 1'b0;
        end else if (i_hready) begin
            ap_addr_q <= {i_haddr[7:2], 2'b00};
            ap_write_q <= i_hwrite;
            ap_valid_q <= bus_take;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end else begin
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end
    end

    // Read data registered from the address phase; unmapped reads zero
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_hrdata <= 32'h00000000;
        end else if (bus_take && !i_hwrite) begin
            case ({i_haddr[7:2], 2'b00})
                bca_pkg::REG_CTRL: begin
                    o_hrdata <= 32'({reg_q.mute, reg_q.enable});
                end
                bca_pkg::REG_QUANT: begin
                    o_hrdata <= 32'({reg_q.headroom_db, reg_q.range_db});
                end
                bca_pkg::REG_DC_BIAS: begin
                    o_hrdata <= 32'(unsigned'(reg_q.dc_bias_level));
                end
                bca_pkg::REG_MIX: begin
                    o_hrdata <= 32'({reg_q.alias_mix, 1'b0,
                                     reg_q.quant_mix});
                end
                bca_pkg::REG_MOD_FREQ: begin
                    o_hrdata <= 32'({reg_q.fine_ct, 1'b0, reg_q.coarse_hz});
                end
                bca_pkg::REG_MOD_DEPTH: begin
                    o_hrdata <= 32'(reg_q.modulation_depth);
                end
                bca_pkg::REG_OUT_GAIN: begin
                    o_hrdata <= 32'(unsigned'(reg_q.gain_db));
                end
                bca_pkg::REG_STATUS: begin
                    o_hrdata <= 32'({(state_q != BCA_IDLE), sample_count_q});
                end
                default: begin
                    o_hrdata <= 32'h00000000;
                end
            endcase
        end
    end

    // Register writes in the data phase
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            reg_q.enable <= bca_pkg::RST_ENABLE;
            reg_q.mute <= bca_pkg::RST_MUTE;
            reg_q.range_db <= bca_pkg::RST_RANGE_DB;
            reg_q.headroom_db <= bca_pkg::RST_HEAD_DB;
            reg_q.dc_bias_level <= bca_pkg::RST_DC_DB;
            reg_q.quant_mix <= bca_pkg::RST_QUANT_MIX;
            reg_q.alias_mix <= bca_pkg::RST_ALIAS_MIX;
            reg_q.coarse_hz <= bca_pkg::RST_COARSE_HZ;
            reg_q.fine_ct <= bca_pkg::RST_FINE_CT;
            reg_q.modulation_depth <= bca_pkg::RST_DEPTH;
            reg_q.gain_db <= bca_pkg::RST_GAIN_DB;
        end else if (ap_valid_q && ap_write_q) begin
            case (ap_addr_q)
                bca_pkg::REG_CTRL: begin
                    reg_q.enable <= i_hwdata[bca_pkg::CTRL_ENABLE_BIT];
                    reg_q.mute <= i_hwdata[bca_pkg::CTRL_MUTE_BIT];
                end
                bca_pkg::REG_QUANT: begin
                    reg_q.range_db <= i_hwdata[bca_pkg::QUANT_RANGE_LSB+:8];
                    reg_q.headroom_db <= i_hwdata[bca_pkg::QUANT_HEAD_LSB+:8];
                end
                bca_pkg::REG_DC_BIAS: begin
                    reg_q.dc_bias_level <= signed'(i_hwdata[10:0]);
                end
                bca_pkg::REG_MIX: begin
                    reg_q.quant_mix <= i_hwdata[bca_pkg::MIX_QUANT_LSB+:7];
                    reg_q.alias_mix <= i_hwdata[bca_pkg::MIX_ALIAS_LSB+:7];
                end
                bca_pkg::REG_MOD_FREQ: begin
                    reg_q.coarse_hz <= i_hwdata[bca_pkg::MODF_COARSE_LSB+:15];
                    reg_q.fine_ct <= signed'(
                        i_hwdata[bca_pkg::MODF_FINE_LSB+:8]);
                end
                bca_pkg::REG_MOD_DEPTH: begin
                    reg_q.modulation_depth <= i_hwdata[5:0];
                end
                bca_pkg::REG_OUT_GAIN: begin
                    reg_q.gain_db <= signed'(i_hwdata[10:0]);
                end
                default: begin
                end
            endcase
        end
    end

    assign dc_lin = db_lin(cfg_q.dc_bias_level, bca_pkg::DC_UNITY_LOG2);
    assign gain_lin = db_lin(cfg_q.gain_db, bca_pkg::GAIN_UNITY_LOG2);
    assign cut = 5'(bca_pkg::MAX_BITS) - kept_bits(cfg_q.range_db);
    assign boost = (cfg_q.range_db < cfg_q.headroom_db) ?
                   5'(bca_pkg::MAX_BITS) - kept_bits(cfg_q.headroom_db) :
                   cut;
    assign tri_w = phase_q[bca_pkg::PHASE_W-1] ?
                   ~phase_q[bca_pkg::PHASE_W-2-:8] :
                   phase_q[bca_pkg::PHASE_W-2-:8];

    always_comb begin
        logic [63:0] f;
        f = 64'(cfg_q.coarse_hz);
        f = f * 64'(bca_pkg::UNITY_Q16 +
                    int'(cfg_q.fine_ct) * bca_pkg::CENT_STEP_Q16);
        f = (f * 64'(bca_pkg::PHASE_K)) >> bca_pkg::PHASE_SHIFT;
        phase_inc = f[bca_pkg::PHASE_W-1:0];
    end

    always_comb begin
        depth_c = cfg_q.modulation_depth;
        if (depth_c < 6'(bca_pkg::DEPTH_MIN)) begin
            depth_c = 6'(bca_pkg::DEPTH_MIN);
        end else if (depth_c > 6'(bca_pkg::DEPTH_MAX)) begin
            depth_c = 6'(bca_pkg::DEPTH_MAX);
        end
    end

    assign rd_addr = wr_ptr_q - depth_c;
    assign mem_we = (state_q == BCA_ALIAS);

    bca_delay_mem #(
        .AW(bca_pkg::MEM_AW),
        .DW(SAMPLE_W)
    ) u_delay (
        .i_clock(i_clock),
        .i_wr_en(mem_we),
        .i_wr_addr(wr_ptr_q),
        .i_wr_data(stage1_q),
        .i_rd_addr(rd_addr),
        .o_rd_data(rd_data)
    );

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            state_q <= BCA_IDLE;
        end else begin
            case (state_q)
                BCA_IDLE: begin
                    if (i_in.valid) begin
                        state_q <= BCA_BIAS;
                    end
                end
                BCA_BIAS: state_q <= BCA_QUANT;
                BCA_QUANT: state_q <= BCA_QMIX;
                BCA_QMIX: state_q <= BCA_ALIAS;
                BCA_ALIAS: state_q <= BCA_AMIX;
                BCA_AMIX: state_q <= BCA_GAIN;
                BCA_GAIN: state_q <= BCA_IDLE;
                default: state_q <= BCA_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            cfg_q <= '0;
            in_q <= '0;
        end else if (state_q == BCA_IDLE && i_in.valid) begin
            cfg_q <= reg_q;
            in_q <= i_in.data;
        end
    end

    // Quantizer stages
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            bias_q <= '0;
            quant_q <= '0;
            stage1_q <= '0;
        end else begin
            if (state_q == BCA_BIAS) begin
                bias_q <= sat(48'(in_q) + 48'(dc_lin));
            end
            if (state_q == BCA_QUANT) begin
                quant_q <= (bias_q >>> cut) <<< boost;
            end
            if (state_q == BCA_QMIX) begin
                stage1_q <= blend(in_q, quant_q,
                                  {1'b0, pct_coef(cfg_q.quant_mix)},
                                  bca_pkg::MIX_COEF_W);
            end
        end
    end

    // Aliaser stages; sweeping the tap blend folds pitch without resampling
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            alias_q <= '0;
            stage2_q <= '0;
            phase_q <= '0;
            wr_ptr_q <= '0;
        end else begin
            if (state_q == BCA_ALIAS) begin
                alias_q <= blend(stage1_q, rd_data, {1'b0, tri_w}, 8);
                phase_q <= phase_q + phase_inc;
            end
            if (state_q == BCA_AMIX) begin
                stage2_q <= blend(stage1_q, alias_q,
                                  {1'b0, pct_coef(cfg_q.alias_mix)},
                                  bca_pkg::MIX_COEF_W);
            end
            if (state_q == BCA_GAIN) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
        end
    end

    // Output stage and stream handshake
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_out <= '0;
            o_in_ready <= 1'b1;
            sample_count_q <= 16'h0000;
        end else begin
            o_out.valid <= 1'b0;
            if (state_q == BCA_IDLE && i_in.valid) begin
                o_in_ready <= 1'b0;
            end
            if (state_q == BCA_GAIN) begin
                o_out.valid <= 1'b1;
                o_in_ready <= 1'b1;
                sample_count_q <= sample_count_q + 16'h0001;
                if (cfg_q.mute) begin
                    o_out.data <= '0;
                end else if (cfg_q.enable) begin
                    o_out.data <= sat((48'(stage2_q) *
                                       $signed({1'b0, gain_lin[19:0]})) >>>
                                      bca_pkg::GAIN_UNITY_LOG2);
                end else begin
                    o_out.data <= sat((48'(in_q) *
                                       $signed({1'b0, gain_lin[19:0]})) >>>
                                      bca_pkg::GAIN_UNITY_LOG2);
                end
            end
        end
    end

    // Transfer size is always a word on this bus; other sizes act the same
    logic unused_ok;
    assign unused_ok = ^i_hsize;
endmodule

/* File: test/bca_effect_monitor.sv */
// Port-level timing checks for the bit crush and alias effect
`timescale 1ns/1ns
module bca_effect_monitor (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // Register bus
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic i_hready,
    input wire logic [31:0] o_hrdata,
    input wire logic o_hreadyout,
    input wire logic o_hresp,
    // Sample stream
    input wire bca_pkg::bca_sample_t i_in,
    input wire logic o_in_ready,
    input wire bca_pkg::bca_sample_t o_out
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_rst);
    logic take;
    logic rd_req;
    assign take = o_in_ready && i_in.valid;
    assign rd_req = i_hsel && i_htrans[1] && i_hready && !i_hwrite;
    ready_okay_a: assert property (o_hreadyout && !o_hresp)
        else $error("bus not ready or not okay");
    out_latency_a: assert property (
        take |=> !o_out.valid [*6] ##1 o_out.valid)
        else $error("output not seven cycles after take");
    busy_span_a: assert property (
        take |=> !o_in_ready [*6] ##1 o_in_ready)
        else $error("input ready wrong while busy");
    pulse_once_a: assert property (
        o_out.valid |=> !o_out.valid)
        else $error("output valid longer than one cycle");
    data_hold_a: assert property (
        !o_out.valid |-> $stable(o_out.data))
        else $error("output data moved between samples");
    no_spurious_a: assert property (
        o_out.valid |-> $past(take, 7))
        else $error("output without a taken sample");
    ready_rise_a: assert property (
        $rose(o_in_ready) |-> o_out.valid)
        else $error("ready returned without output");
    unmapped_zero_a: assert property (
        rd_req && i_haddr[7:5] != 3'h0 |=> o_hrdata == 32'h0)
        else $error("unmapped read not zero");
    ctrl_upper_a: assert property (
        rd_req && i_haddr[7:2] == 6'h0 |=> o_hrdata[31:2] == 30'h0)
        else $error("control upper bits not zero");
    rdata_hold_a: assert property (!rd_req |=> $stable(o_hrdata))
        else $error("read data changed without a read");
    cover property (take);
    cover property (take && o_out.valid);
    cover property (rd_req && i_haddr[7:5] != 3'h0);
endmodule

bind bca_effect bca_effect_monitor u_mon (.i_clock(i_clock), .i_rst(i_rst),
    .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
    .i_hwrite(i_hwrite), .i_hready(i_hready), .o_hrdata(o_hrdata),
    .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_in(i_in),
    .o_in_ready(o_in_ready), .o_out(o_out));

/* File: test/testbench.sv */
// Self-checking bench for the bit crush and alias effect
`timescale 1ns/1ns
module testbench;
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    bca_pkg::bca_sample_t s_in = '0;
    bca_pkg::bca_sample_t s_out;
    logic in_ready;
    int n_errors = 0;
    int n_checks = 0;
    int n_out = 0;
    logic [31:0] rv;
    logic [23:0] y;
    // Quantizer table: QUANT word, input, expected output
    logic [31:0] qv [7] = '{32'h0, 32'h0, 32'h0, 32'h6, 32'hC, 32'hC, 32'hC00};
    logic [23:0] xv [7] = '{24'h400000, 24'hC00000, 24'hFFFFFF, 24'h500000,
        24'h700000, 24'h300000, 24'hC00000};
    logic [23:0] ev [7] = '{24'h0, 24'h800000, 24'h0, 24'h400000,
        24'h600000, 24'h200000, 24'hE00000};

    always #20 i_clock = ~i_clock;

    bca_effect DUT (.i_clock(i_clock), .i_rst(i_rst), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
        .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
        .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
        .i_in(s_in), .o_in_ready(in_ready), .o_out(s_out));

    task close_out();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task give_up();
        n_errors++;
        $display("mismatch at %0t: wait ran out", $time);
        close_out();
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Ready is polled, never assumed, though the slave has no wait states
    task wait_bus();
        int n;
        n = 0;
        do begin
            @(posedge i_clock);
            n++;
        end while (hready !== 1'b1 && n < 100);
        if (hready !== 1'b1)
            give_up();
    endtask

    task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clock);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_bus();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_bus();
        rv = hrdata;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task rd_chk(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        check(rv, e);
    endtask

    // Extra holds valid into the busy span, which must be ignored
    task send(input logic [23:0] x, input int extra);
        int n;
        @(posedge i_clock);
        s_in.valid <= 1'b1;
        s_in.data <= x;
        n = 0;
        do begin
            @(posedge i_clock);
            n++;
        end while (in_ready !== 1'b1 && n < 100);
        if (in_ready !== 1'b1)
            give_up();
        repeat (extra) @(posedge i_clock);
        s_in.valid <= 1'b0;
        s_in.data <= ~x;
        n = 0;
        do begin
            @(posedge i_clock);
            n++;
        end while (s_out.valid !== 1'b1 && n < 100);
        if (s_out.valid !== 1'b1)
            give_up();
        y = s_out.data;
        n_out++;
    endtask

    task run(input logic [23:0] x, input logic [23:0] e);
        send(x, 0);
        check({8'h0, y}, {8'h0, e});
    endtask

    initial begin
        repeat (8) @(posedge i_clock);
        i_rst <= 1'b0;
        rd_chk(bca_pkg::REG_CTRL, 32'h0);
        rd_chk(bca_pkg::REG_QUANT, 32'h90);
        rd_chk(bca_pkg::REG_DC_BIAS, 32'h4EA);
        rd_chk(bca_pkg::REG_MIX, 32'h6464);
        rd_chk(bca_pkg::REG_MOD_FREQ, 32'h1B8);
        rd_chk(bca_pkg::REG_MOD_DEPTH, 32'h1);
        rd_chk(bca_pkg::REG_OUT_GAIN, 32'h0);
        rd_chk(8'h20, 32'h0);
        // Fill every delay word so the unreset line never reads unknowns
        for (int i = 0; i < 64; i++)
            send(24'h0, 0);
        check({8'h0, y}, 32'h0);
        wr(bca_pkg::REG_MOD_FREQ, 32'h009C6200);
        rd_chk(bca_pkg::REG_MOD_FREQ, 32'h009C6200);
        wr(bca_pkg::REG_MOD_DEPTH, 32'h31);
        rd_chk(bca_pkg::REG_MOD_DEPTH, 32'h31);
        run(24'h123456, 24'h123456);
        wr(bca_pkg::REG_OUT_GAIN, 32'h7C4);
        run(24'h123456, 24'h091A2B);
        wr(bca_pkg::REG_OUT_GAIN, 32'h3C);
        run(24'h100000, 24'h200000);
        wr(bca_pkg::REG_OUT_GAIN, 32'h0);
        wr(bca_pkg::REG_CTRL, 32'h2);
        run(24'h123456, 24'h0);
        wr(bca_pkg::REG_CTRL, 32'h1);
        wr(bca_pkg::REG_MIX, 32'h0);
        run(24'h3456AB, 24'h3456AB);
        wr(bca_pkg::REG_MIX, 32'h64);
        for (int i = 0; i < 7; i++) begin
            wr(bca_pkg::REG_QUANT, qv[i]);
            run(xv[i], ev[i]);
        end
        wr(bca_pkg::REG_QUANT, 32'h0);
        wr(bca_pkg::REG_MIX, 32'h32);
        send(24'h400000, 0);
        check(y > 24'h1FFF00 && y < 24'h200100, 32'h1);
        wr(bca_pkg::REG_CTRL, 32'h0);
        fork
            send(24'h0ABCDE, 0);
            begin
                repeat (3) @(posedge i_clock);
                wr(bca_pkg::REG_CTRL, 32'h2);
            end
        join
        check({8'h0, y}, 32'h0ABCDE);
        run(24'h0ABCDE, 24'h0);
        wr(bca_pkg::REG_CTRL, 32'h0);
        send(24'h000001, 3);
        wr(bca_pkg::REG_STATUS, 32'hFFFF);
        rd_chk(bca_pkg::REG_STATUS, {16'h0, n_out[15:0]});
        // Steady input fills the delay line, so modulation must add nothing
        wr(bca_pkg::REG_CTRL, 32'h1);
        wr(bca_pkg::REG_MIX, 32'h6400);
        for (int i = 0; i < 52; i++)
            send(24'h123400, 0);
        check({8'h0, y}, 32'h123400);
        close_out();
    end

    initial begin
        repeat (20000) @(posedge i_clock);
        n_errors++;
        $display("mismatch at %0t: run too long", $time);
        close_out();
    end
endmodule
